// file: hibpc_pkg.sv
// Constants, field layouts and carrier types of the hibernation power controller
package hibpc_pkg;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [11:0] HIBPC_OFF_CTRL = 12'h000;
	localparam logic [11:0] HIBPC_OFF_MASK = 12'h004;
	localparam logic [11:0] HIBPC_OFF_RAW = 12'h008;
	localparam logic [11:0] HIBPC_OFF_MASKED = 12'h00C;
	localparam logic [11:0] HIBPC_OFF_CLEAR = 12'h010;
	localparam logic [3:0] HIBPC_MEM_PAGE = 4'h1;
	localparam int HIBPC_MEM_WORDS = 64;

	// ------------------------------------------------------------
	// Control register bit positions
	// ------------------------------------------------------------
	localparam int HIBPC_CTRL_ENABLE = 0;
	localparam int HIBPC_CTRL_CLKSRC = 1;
	localparam int HIBPC_CTRL_REQUEST = 2;
	localparam int HIBPC_CTRL_WAKE_PIN = 3;
	localparam int HIBPC_CTRL_WAKE_RTC = 4;
	localparam int HIBPC_CTRL_LOWBATT = 5;
	localparam int HIBPC_CTRL_REG_ON = 8;

	// ------------------------------------------------------------
	// Event bit positions, shared by mask, raw, masked and clear
	// ------------------------------------------------------------
	localparam int HIBPC_EVT_PIN_WAKE = 0;
	localparam int HIBPC_EVT_LOW_BATTERY = 1;
	localparam int HIBPC_EVT_RTC_MATCH0 = 2;
	localparam int HIBPC_EVT_RTC_MATCH1 = 3;

	// ------------------------------------------------------------
	// Time base
	// ------------------------------------------------------------
	localparam int HIBPC_OSC_HZ = 32768;
	localparam int HIBPC_XTAL_HZ = 4194304;
	localparam int HIBPC_XTAL_DIV = HIBPC_XTAL_HZ / HIBPC_OSC_HZ;
	localparam logic [6:0] HIBPC_DIV_LAST = 7'(HIBPC_XTAL_DIV - 1);
	localparam logic [6:0] HIBPC_DIV_RESET = 7'h00;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [3:0] HIBPC_EVT_RESET = 4'h0;
	localparam logic [31:0] HIBPC_DATA_RESET = 32'h00000000;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic lowbatt_detect_and_abort;
		logic wake_rtc_en;
		logic wake_pin_en;
		logic clk_src_crystal_divided;
		logic enable;
	} hibpc_ctrl_type;

	localparam hibpc_ctrl_type HIBPC_CTRL_RESET = 5'h00;

	typedef struct packed {
		logic wake_pin;
		logic low_battery;
		logic osc_32k;
		logic xtal_in;
	} hibpc_pins_type;

	localparam hibpc_pins_type HIBPC_PINS_RESET = 4'h0;

endpackage

// file: hibpc_top.sv
// Hibernation power controller: time base, retention memory, events and regulator control
//
// Summary of operation
// [RL1] Time base from raw low-frequency oscillator or crystal divided by 128.
// [RL2] Sixty-four 32-bit retention words survive processor power removal.
// [RL3] A retention read returns the last value written to that word.
// [RL4] While disabled, no time base, events, retention access or hibernation.
// [RL5] Software enables the module before using any of its functions.
// [RL6] Four maskable event sources: wake pin, low battery, RTC match 0 and 1.
// [RL7] Masked-off sources stop driving the interrupt; others stay unaffected.
// [RL8] Pending sources stay set until cleared, holding the interrupt if enabled.
// [RL9] Software clears sources early in its handler because clears lag.
// [RL10] Raw and masked status are both readable.
// [RL11] Both status readouts use the mask's bit positions.
// [RL12] Interrupt is raised only for sources whose enable bit is set.
// [RL13] Active bit survives processor reset, telling wake from cold start.
// [RL14] Raw status still holds the wake cause after power returns.
// [RL15] Low-battery policy: detect only, or detect and abort hibernation.
// [RL16] The low-battery policy reads back.
// [RL17] A detected low battery sets its raw bit and can interrupt.
// [RL18] Request turns regulator off; a configured wake turns it back on.
// [RL19] Wake from pin, RTC match or both, one enable each.
// [RL20] Masked bit is raw AND enable; interrupt is OR of masked bits.
// [RL21] Clear is write-one-to-clear; zeros leave bits unchanged.
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/100ps

module hibpc_top (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Battery-backed domain reset
	input wire logic vbat_rstn,
	// Asynchronous pins
	input wire hibpc_pkg::hibpc_pins_type pins_in,
	// RTC match events
	input wire logic rtc_match0,
	input wire logic rtc_match1,
	// Outputs
	output logic tb_tick,
	output logic irq,
	output logic regulator_en
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	hibpc_pkg::hibpc_pins_type sync1, sync2, sync3, filt, filt_d, next_filt;
	hibpc_pkg::hibpc_ctrl_type ctrl, next_ctrl;
	logic [3:0] mask, next_mask, raw, next_raw, ev_set, clr_bits;
	logic [6:0] div_cnt, next_div_cnt;
	logic next_tb_tick, next_irq, next_regulator_en;
	logic [31:0] next_prdata, rd_mux;
	logic next_pready, next_pslverr;
	logic [31:0] mem [hibpc_pkg::HIBPC_MEM_WORDS];
	logic acc_first, done, wr, is_mem, is_reg, addr_ok, req_now, abort, wake;
	logic osc_rise, xtal_rise, pin_rise;
	logic [5:0] mem_idx;

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		next_filt = hibpc_pkg::hibpc_pins_type'((~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & filt));
		osc_rise = filt.osc_32k & ~filt_d.osc_32k;
		xtal_rise = filt.xtal_in & ~filt_d.xtal_in;
		pin_rise = filt.wake_pin & ~filt_d.wake_pin;
		acc_first = psel & penable & ~pready;
		done = psel & penable & pready;
		wr = done & pwrite;
		mem_idx = paddr[7:2];
		is_mem = (paddr[11:8] == hibpc_pkg::HIBPC_MEM_PAGE) & (paddr[1:0] == 2'h0);
		is_reg = (paddr == hibpc_pkg::HIBPC_OFF_CTRL) | (paddr == hibpc_pkg::HIBPC_OFF_MASK)
			| (paddr == hibpc_pkg::HIBPC_OFF_RAW) | (paddr == hibpc_pkg::HIBPC_OFF_MASKED)
			| (paddr == hibpc_pkg::HIBPC_OFF_CLEAR);
		addr_ok = is_mem | is_reg;
		// Events only arise while enabled
		ev_set = 4'h0;
		ev_set[hibpc_pkg::HIBPC_EVT_PIN_WAKE] = ctrl.enable & pin_rise; // [RL6] [RL4]
		ev_set[hibpc_pkg::HIBPC_EVT_LOW_BATTERY] = ctrl.enable & filt.low_battery; // [RL17]
		ev_set[hibpc_pkg::HIBPC_EVT_RTC_MATCH0] = ctrl.enable & rtc_match0; // [RL6]
		ev_set[hibpc_pkg::HIBPC_EVT_RTC_MATCH1] = ctrl.enable & rtc_match1; // [RL6]
		// Control register; the active bit lives in the battery domain
		next_ctrl = ctrl;
		if (wr && paddr == hibpc_pkg::HIBPC_OFF_CTRL) begin
			next_ctrl.enable = pwdata[hibpc_pkg::HIBPC_CTRL_ENABLE]; // [RL13]
			next_ctrl.clk_src_crystal_divided = pwdata[hibpc_pkg::HIBPC_CTRL_CLKSRC]; // [RL1]
			next_ctrl.wake_pin_en = pwdata[hibpc_pkg::HIBPC_CTRL_WAKE_PIN]; // [RL19]
			next_ctrl.wake_rtc_en = pwdata[hibpc_pkg::HIBPC_CTRL_WAKE_RTC]; // [RL19]
			next_ctrl.lowbatt_detect_and_abort = pwdata[hibpc_pkg::HIBPC_CTRL_LOWBATT]; // [RL15]
		end
		next_mask = mask;
		if (wr && ctrl.enable && paddr == hibpc_pkg::HIBPC_OFF_MASK) begin
			next_mask = pwdata[3:0]; // [RL7]
		end
		clr_bits = 4'h0;
		if (wr && ctrl.enable && paddr == hibpc_pkg::HIBPC_OFF_CLEAR) begin
			clr_bits = pwdata[3:0]; // [RL21]
		end
		// Set wins over clear; bits persist over processor reset
		next_raw = (raw & ~clr_bits) | ev_set; // [RL8] [RL14]
		next_irq = |(next_raw & next_mask); // [RL12] [RL20]
		// Hibernation request and wake
		req_now = wr & ctrl.enable & (paddr == hibpc_pkg::HIBPC_OFF_CTRL) & pwdata[hibpc_pkg::HIBPC_CTRL_REQUEST];
		abort = ctrl.lowbatt_detect_and_abort & filt.low_battery; // [RL15]
		wake = (ctrl.wake_pin_en & ev_set[hibpc_pkg::HIBPC_EVT_PIN_WAKE])
			| (ctrl.wake_rtc_en & (ev_set[hibpc_pkg::HIBPC_EVT_RTC_MATCH0]
			| ev_set[hibpc_pkg::HIBPC_EVT_RTC_MATCH1])); // [RL19]
		next_regulator_en = regulator_en;
		if (!ctrl.enable) begin
			next_regulator_en = 1'b1; // [RL4]
		end else if (!regulator_en && wake) begin
			next_regulator_en = 1'b1; // [RL18]
		end else if (req_now && !abort) begin
			next_regulator_en = 1'b0; // [RL18]
		end
		// Time base
		next_div_cnt = div_cnt;
		next_tb_tick = 1'b0;
		if (!ctrl.enable) begin
			next_div_cnt = hibpc_pkg::HIBPC_DIV_RESET; // [RL4]
		end else if (ctrl.clk_src_crystal_divided) begin
			if (xtal_rise) begin
				if (div_cnt == hibpc_pkg::HIBPC_DIV_LAST) begin
					next_div_cnt = hibpc_pkg::HIBPC_DIV_RESET; // [RL1]
					next_tb_tick = 1'b1;
				end else begin
					next_div_cnt = div_cnt + 7'h01;
				end
			end
		end else begin
			next_div_cnt = hibpc_pkg::HIBPC_DIV_RESET;
			next_tb_tick = osc_rise; // [RL1]
		end
		// Read data
		rd_mux = hibpc_pkg::HIBPC_DATA_RESET;
		if (is_mem) begin
			rd_mux = ctrl.enable ? mem[mem_idx] : hibpc_pkg::HIBPC_DATA_RESET; // [RL3] [RL4]
		end else if (paddr == hibpc_pkg::HIBPC_OFF_CTRL) begin
			rd_mux[hibpc_pkg::HIBPC_CTRL_ENABLE] = ctrl.enable; // [RL13]
			rd_mux[hibpc_pkg::HIBPC_CTRL_CLKSRC] = ctrl.clk_src_crystal_divided;
			rd_mux[hibpc_pkg::HIBPC_CTRL_WAKE_PIN] = ctrl.wake_pin_en;
			rd_mux[hibpc_pkg::HIBPC_CTRL_WAKE_RTC] = ctrl.wake_rtc_en;
			rd_mux[hibpc_pkg::HIBPC_CTRL_LOWBATT] = ctrl.lowbatt_detect_and_abort; // [RL16]
			rd_mux[hibpc_pkg::HIBPC_CTRL_REG_ON] = regulator_en;
		end else if (paddr == hibpc_pkg::HIBPC_OFF_MASK) begin
			rd_mux[3:0] = mask;
		end else if (paddr == hibpc_pkg::HIBPC_OFF_RAW) begin
			rd_mux[3:0] = raw; // [RL10] [RL11]
		end else if (paddr == hibpc_pkg::HIBPC_OFF_MASKED) begin
			rd_mux[3:0] = raw & mask; // [RL10] [RL11] [RL20]
		end
		next_prdata = prdata;
		if (acc_first) begin
			next_prdata = pwrite ? hibpc_pkg::HIBPC_DATA_RESET : rd_mux;
		end
		next_pready = acc_first;
		next_pslverr = acc_first & ~addr_ok;
	end

	// ------------------------------------------------------------
	// Bus-side registers, reset by processor reset
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= hibpc_pkg::HIBPC_DATA_RESET;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// ------------------------------------------------------------
	// Battery-backed registers, untouched by processor reset
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge vbat_rstn) begin
		if (!vbat_rstn) begin
			sync1 <= hibpc_pkg::HIBPC_PINS_RESET;
			sync2 <= hibpc_pkg::HIBPC_PINS_RESET;
			sync3 <= hibpc_pkg::HIBPC_PINS_RESET;
			filt <= hibpc_pkg::HIBPC_PINS_RESET;
			filt_d <= hibpc_pkg::HIBPC_PINS_RESET;
			ctrl <= hibpc_pkg::HIBPC_CTRL_RESET;
			mask <= hibpc_pkg::HIBPC_EVT_RESET;
			raw <= hibpc_pkg::HIBPC_EVT_RESET;
			div_cnt <= hibpc_pkg::HIBPC_DIV_RESET;
			tb_tick <= 1'b0;
			irq <= 1'b0;
			regulator_en <= 1'b1;
		end else begin
			sync1 <= pins_in;
			sync2 <= sync1;
			sync3 <= sync2;
			filt <= next_filt;
			filt_d <= filt;
			ctrl <= next_ctrl;
			mask <= next_mask;
			raw <= next_raw;
			div_cnt <= next_div_cnt;
			tb_tick <= next_tb_tick;
			irq <= next_irq;
			regulator_en <= next_regulator_en;
		end
	end

	// ------------------------------------------------------------
	// Retention memory, never reset
	// ------------------------------------------------------------
	always_ff @(posedge pclk) begin
		if (wr && is_mem && ctrl.enable) begin
			mem[mem_idx] <= pwdata; // [RL2] [RL3]
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	AST_IRQ_MASKED: assert property (@(posedge pclk) disable iff (!presetn || !vbat_rstn) // [RL12]
		irq == |(raw & mask)) else $error("irq differs from OR of masked status");

	AST_DISABLED_NO_TICK: assert property (@(posedge pclk) disable iff (!presetn || !vbat_rstn) // [RL4]
		!ctrl.enable |=> !tb_tick) else $error("time base ticked while disabled");

	AST_DIV_SPACING: assert property (@(posedge pclk) disable iff (!presetn || !vbat_rstn) // [RL1]
		(tb_tick && ctrl.clk_src_crystal_divided) |=> !tb_tick [*8]) else $error("divided tick too close");

	AST_W1C: assert property (@(posedge pclk) disable iff (!presetn || !vbat_rstn) // [RL21]
		(|clr_bits && !(|ev_set)) |=> ((raw & $past(clr_bits)) == 4'h0)) else $error("clear did not clear");

	AST_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn || !vbat_rstn) // [RL8]
		|ev_set |=> ((raw & $past(ev_set)) == $past(ev_set))) else $error("event lost");

	AST_ABORT: assert property (@(posedge pclk) disable iff (!presetn || !vbat_rstn) // [RL15]
		(req_now && abort && regulator_en) |=> regulator_en) else $error("request not aborted on low battery");

	AST_REQUEST_OFF: assert property (@(posedge pclk) disable iff (!presetn || !vbat_rstn) // [RL18]
		(req_now && !abort && !(!regulator_en && wake)) |=> !regulator_en) else $error("regulator not turned off");

	AST_WAKE_ON: assert property (@(posedge pclk) disable iff (!presetn || !vbat_rstn) // [RL19]
		(!regulator_en && wake && ctrl.enable) |=> regulator_en) else $error("wake did not restore regulator");

	AST_MEM_READ: assert property (@(posedge pclk) disable iff (!presetn || !vbat_rstn) // [RL3]
		(done && !pwrite && is_mem && ctrl.enable) |-> prdata == mem[mem_idx]) else $error("retention read mismatch");

	AST_PREADY: assert property (@(posedge pclk) disable iff (!presetn || !vbat_rstn) // [RL10]
		acc_first |=> (pready && !$past(pready))) else $error("pready not one wait state");

endmodule // hibpc_top

// file: tb.sv
// Self-checking testbench of the hibernation power controller
`timescale 1ns/100ps

module tb;
	logic pclk, presetn, psel, penable, pwrite, vbat_rstn, rtc_match0, rtc_match1;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, tb_tick, irq, regulator_en, err;
	hibpc_pkg::hibpc_pins_type pins;
	int fails, total_checks, ticks, i;

	hibpc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.vbat_rstn(vbat_rstn), .pins_in(pins), .rtc_match0(rtc_match0), .rtc_match1(rtc_match1),
		.tb_tick(tb_tick), .irq(irq), .regulator_en(regulator_en));

	// ------------------------------------------------------------
	// Clock, tick counter and helpers
	// ------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		if (tb_tick === 1'b1) ticks++;
	end

	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
			if (n > 50) begin
				fails++;
				test_done();
			end
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	task automatic tog_osc(input int n);
		repeat (n) begin
			pins.osc_32k <= 1'b1;
			wt(4);
			pins.osc_32k <= 1'b0;
			wt(4);
		end
		wt(8);
	endtask

	task automatic por();
		presetn <= 1'b0;
		wt(2);
		presetn <= 1'b1;
		wt(1);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		fails = 0;
		total_checks = 0;
		ticks = 0;
		presetn = 1'b0;
		vbat_rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		rtc_match0 = 1'b0;
		rtc_match1 = 1'b0;
		pins = hibpc_pkg::HIBPC_PINS_RESET;
		wt(5);
		presetn <= 1'b1;
		vbat_rstn <= 1'b1;
		@(posedge pclk);
		rdc(hibpc_pkg::HIBPC_OFF_CTRL, 32'h00000100);
		rdc(12'h020, 32'h00000000);
		chk(err, 1'b1);
		apb(1'b1, 12'h100, 32'hA5A5A5A5);
		rdc(12'h100, 32'h00000000);
		apb(1'b1, hibpc_pkg::HIBPC_OFF_MASK, 32'h0000000F);
		rdc(hibpc_pkg::HIBPC_OFF_MASK, 32'h00000000);
		tog_osc(3);
		chk(ticks, 0);
		apb(1'b1, hibpc_pkg::HIBPC_OFF_CTRL, 32'h00000001);
		rdc(hibpc_pkg::HIBPC_OFF_CTRL, 32'h00000101);
		ticks = 0;
		tog_osc(3);
		chk(ticks, 3);
		apb(1'b1, hibpc_pkg::HIBPC_OFF_CTRL, 32'h00000003);
		ticks = 0;
		repeat (256) begin
			pins.xtal_in <= 1'b1;
			wt(4);
			pins.xtal_in <= 1'b0;
			wt(4);
		end
		wt(8);
		chk(ticks, 2);
		apb(1'b1, hibpc_pkg::HIBPC_OFF_CTRL, 32'h00000001);
		for (i = 0; i < 64; i += 21) apb(1'b1, 12'h100 + 12'(4 * i), 32'hC0DE0000 | i);
		for (i = 0; i < 64; i += 21) rdc(12'h100 + 12'(4 * i), 32'hC0DE0000 | i);
		por();
		rdc(12'h1FC, 32'hC0DE003F);
		rdc(hibpc_pkg::HIBPC_OFF_CTRL, 32'h00000101);
		apb(1'b1, hibpc_pkg::HIBPC_OFF_MASK, 32'h0000000F);
		rtc_match0 <= 1'b1;
		@(posedge pclk);
		rtc_match0 <= 1'b0;
		wt(3);
		chk(irq, 1'b1);
		rdc(hibpc_pkg::HIBPC_OFF_RAW, 32'h00000004);
		apb(1'b1, hibpc_pkg::HIBPC_OFF_MASK, 32'h0000000B);
		rdc(hibpc_pkg::HIBPC_OFF_MASKED, 32'h00000000);
		chk(irq, 1'b0);
		rtc_match1 <= 1'b1;
		@(posedge pclk);
		rtc_match1 <= 1'b0;
		wt(3);
		rdc(hibpc_pkg::HIBPC_OFF_RAW, 32'h0000000C);
		rdc(hibpc_pkg::HIBPC_OFF_MASKED, 32'h00000008);
		chk(irq, 1'b1);
		apb(1'b1, hibpc_pkg::HIBPC_OFF_CLEAR, 32'h00000008);
		rdc(hibpc_pkg::HIBPC_OFF_RAW, 32'h00000004);
		chk(irq, 1'b0);
		apb(1'b1, hibpc_pkg::HIBPC_OFF_CLEAR, 32'h00000004);
		pins.low_battery <= 1'b1;
		wt(8);
		rdc(hibpc_pkg::HIBPC_OFF_RAW, 32'h00000002);
		chk(irq, 1'b1);
		apb(1'b1, hibpc_pkg::HIBPC_OFF_CTRL, 32'h00000021);
		apb(1'b1, hibpc_pkg::HIBPC_OFF_CTRL, 32'h00000025);
		wt(3);
		chk(regulator_en, 1'b1);
		rdc(hibpc_pkg::HIBPC_OFF_CTRL, 32'h00000121);
		pins.low_battery <= 1'b0;
		wt(8);
		apb(1'b1, hibpc_pkg::HIBPC_OFF_CLEAR, 32'h00000002);
		apb(1'b1, hibpc_pkg::HIBPC_OFF_CTRL, 32'h0000000D);
		wt(2);
		chk(regulator_en, 1'b0);
		rdc(hibpc_pkg::HIBPC_OFF_CTRL, 32'h00000009);
		pins.wake_pin <= 1'b1;
		i = 0;
		while (regulator_en !== 1'b1 && i < 20) begin
			@(posedge pclk);
			i++;
		end
		if (i >= 20) begin
			fails++;
			test_done();
		end
		chk(regulator_en, 1'b1);
		por();
		rdc(hibpc_pkg::HIBPC_OFF_RAW, 32'h00000001);
		rdc(hibpc_pkg::HIBPC_OFF_CTRL, 32'h00000109);
		apb(1'b1, hibpc_pkg::HIBPC_OFF_CTRL, 32'h00000015);
		wt(2);
		chk(regulator_en, 1'b0);
		rtc_match1 <= 1'b1;
		@(posedge pclk);
		rtc_match1 <= 1'b0;
		wt(2);
		chk(regulator_en, 1'b1);
		rdc(hibpc_pkg::HIBPC_OFF_RAW, 32'h00000009);
		test_done();
	end
endmodule // tb
